// *** bench/pchp_config_header_checker.sv ***
`timescale 1ns/1ps

module pchp_config_header_checker
    import pchp_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // configuration access
    input wire logic        cfg_rd,
    input wire logic        cfg_wr,
    input wire logic        cfg_ack,
    input wire logic [31:0] cfg_rdata,
    // interrupt side
    input wire logic        iack_cmd,
    input wire logic        iack_enable_in,
    input wire logic        iack_claim,
    input wire logic [7:0]  int_pin_in,
    input wire logic        local_int_b,
    input wire logic        inta_b_oe
);
    // ==========
    // access and interrupt properties
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_take;
        cfg_rd || cfg_wr;
    endsequence
    sequence s_int_on;
        int_pin_in == PCHP_INTPIN_A && !local_int_b;
    endsequence
    a_ack_answer: assert property (s_take |=> cfg_ack)
        else $error("no ack");
    a_ack_cause: assert property (cfg_ack |-> $past(cfg_rd || cfg_wr))
        else $error("stray ack");
    a_rdata_idle: assert property (!cfg_ack |-> cfg_rdata == '0)
        else $error("rdata outside ack");
    a_wr_silent: assert property (cfg_wr |=> cfg_rdata == '0)
        else $error("rdata on write");
    a_iack_claim: assert property (iack_cmd && iack_enable_in |=> iack_claim)
        else $error("no claim");
    a_iack_refuse: assert property (!iack_enable_in |=> !iack_claim)
        else $error("claim while off");
    a_inta_drive: assert property (s_int_on |=> inta_b_oe)
        else $error("inta not driven");
    a_inta_quiet: assert property (int_pin_in != PCHP_INTPIN_A |=> !inta_b_oe)
        else $error("inta without pin");
    a_inta_release: assert property (local_int_b |=> !inta_b_oe)
        else $error("inta held");
endmodule : pchp_config_header_checker

// *** bench/pchp_config_header_tb.sv ***
`timescale 1ns/1ps

module pchp_config_header_tb
    import pchp_pkg::*;
;
    // ==========
    // bench signals
    logic        mclk = 1'b0, rst_b = 1'b0, load = 1'b0;
    logic        cfg_rd = 1'b0, cfg_wr = 1'b0, iack_cmd = 1'b0;
    logic        local_int_b = 1'b1;
    logic [7:0]  cfg_addr = 8'h00;
    logic [3:0]  cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic        cfg_ack, iack_claim, inta_b_o, inta_b_oe;
    logic [31:0] cfg_rdata, ptr, d;
    logic [7:0]  latency_timer_out, lsw, il, lat, ilo;
    logic [63:0] ids;
    logic [47:0] bytes;
    logic [23:0] cls;
    logic [5:0]  flags;
    logic [2:0]  want_int;
    logic [7:0]  addrs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h28, 8'h2D,
                                8'h34, 8'h3C, 8'h30, 8'h40};
    int          errors = 0, compares = 0;

    always #4 mclk = ~mclk;

    pchp_local_model partner (.mclk(mclk), .load(load), .ids(ids),
        .ptr(ptr), .cls(cls), .bytes(bytes), .flags(flags));
    pchp_config_header dut (.mclk(mclk), .rst_b(rst_b), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .maker_ident_in(ids[15:0]), .product_ident_in(ids[31:16]),
        .subsystem_maker_in(ids[47:32]), .subsystem_product_in(ids[63:48]),
        .revision_in(bytes[7:0]), .class_in(cls),
        .decode_speed_in(flags[1:0]), .cap_list_en_in(flags[2]),
        .cap_pointer_in(bytes[15:8]), .card_info_pointer_in(ptr),
        .back_to_back_capable_in(flags[3]), .iack_enable_in(flags[4]),
        .int_pin_in(bytes[23:16]), .hw_latency_en_in(flags[5]),
        .hw_latency_val_in(bytes[31:24]), .min_grant_in(bytes[47:40]),
        .max_latency_in(bytes[39:32]), .iack_cmd(iack_cmd),
        .iack_claim(iack_claim), .local_int_b(local_int_b),
        .inta_b_o(inta_b_o), .inta_b_oe(inta_b_oe),
        .latency_timer_out(latency_timer_out), .int_line_out(ilo));

    // ==========
    // model, compare and access tasks
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        lat = flags[5] ? bytes[31:24] : lsw;
        case (a[7:2])
            6'h00: return ids[31:0];
            6'h01: return {5'h00, flags[1:0], 1'b0, flags[3], 2'h0, flags[2],
                           20'h0_0000};
            6'h02: return {cls, bytes[7:0]};
            6'h03: return {16'h0000, lat, 8'h00};
            6'h0A: return ptr;
            6'h0B: return ids[63:32];
            6'h0D: return {24'h00_0000, bytes[15:8]};
            6'h0F: return {bytes[47:32], bytes[23:16], il};
            default: return 32'h0000_0000;
        endcase
    endfunction : exp_rd

    task automatic chk(input logic [32:0] got, input logic [32:0] want);
        compares++;
        if (got !== want) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [3:0] be);
        logic [31:0] want;
        want = w ? 32'h0000_0000 : exp_rd(a);
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, be, d};
        @(negedge mclk);
        chk({cfg_ack, cfg_rdata}, {1'b1, want});
    endtask : acc

    task automatic wrap_up;
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    initial begin
        void'($urandom(69));
        repeat (4) @(negedge mclk);
        chk({cfg_ack, iack_claim, inta_b_oe, latency_timer_out, ilo}, 0);
        chk(cfg_rdata, 0);
        for (int r = 0; r < 6; r++) begin
            {rst_b, load, lsw, il} = {2'b01, 16'h0000};
            @(negedge mclk);
            {rst_b, load} = 2'b10;
            foreach (addrs[i]) acc(1'b0, addrs[i], 4'h0);
            d = $urandom;
            acc(1'b1, 8'h00, 4'hF);
            acc(1'b1, 8'h40, 4'hF);
            acc(1'b1, 8'h0C, 4'h2);
            acc(1'b1, 8'h3C, 4'h1);
            lsw = flags[5] ? 8'h00 : d[15:8];
            il = d[7:0];
            foreach (addrs[i]) acc(1'b0, addrs[i], 4'h0);
            cfg_rd = 1'b0;
            chk(latency_timer_out, exp_rd(8'h0C) >> 8);
            chk(ilo, il);
            repeat (8) begin
                {iack_cmd, local_int_b} = 2'($urandom);
                want_int = {iack_cmd & flags[4],
                            bytes[23:16] == 8'h01 && !local_int_b, 1'b0};
                @(negedge mclk);
                chk({iack_claim, inta_b_oe, inta_b_o}, want_int);
            end
            local_int_b = 1'b1;
        end
        wrap_up();
    end

    initial begin
        #20us;
        errors++;
        wrap_up();
    end
endmodule : pchp_config_header_tb

bind pchp_config_header pchp_config_header_checker chk (.mclk(mclk),
    .rst_b(rst_b), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .iack_cmd(iack_cmd),
    .iack_enable_in(iack_enable_in), .iack_claim(iack_claim),
    .int_pin_in(int_pin_in), .local_int_b(local_int_b),
    .inta_b_oe(inta_b_oe));

// *** bench/pchp_local_model.sv ***
`timescale 1ns/1ps

module pchp_local_model
    import pchp_pkg::*;
(
    // reload control
    input  wire logic   mclk,
    input  wire logic   load,
    // header values
    output logic [63:0] ids,
    output logic [31:0] ptr,
    output logic [23:0] cls,
    output logic [47:0] bytes,
    output logic [5:0]  flags
);
    // ==========
    // values stay constant between reloads
    initial {ids, ptr, cls, bytes, flags} = '0;
    always @(posedge mclk) begin
        if (load) begin
            ids <= {$urandom, 16'($urandom),
                    16'($urandom_range(16'hFFFE))};
            ptr <= $urandom;
            cls <= 24'($urandom);
            bytes <= {16'($urandom), 8'($urandom_range(16)),
                      8'($urandom_range(1)), 16'($urandom)};
            flags <= {4'($urandom), PCHP_DEVSEL_SLOW};
        end
    end
endmodule : pchp_local_model

// *** rtl/pchp_config_header.sv ***
`timescale 1ns/1ps


module pchp_config_header
    import pchp_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // configuration access from target engine
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic [31:0]      cfg_rdata,
    // configuration space port, static values from local logic
    input  wire logic [15:0] maker_ident_in,
    input  wire logic [15:0] product_ident_in,
    input  wire logic [15:0] subsystem_maker_in,
    input  wire logic [15:0] subsystem_product_in,
    input  wire logic [7:0]  revision_in,
    input  wire logic [23:0] class_in,
    input  wire logic [1:0]  decode_speed_in,
    input  wire logic        cap_list_en_in,
    input  wire logic [7:0]  cap_pointer_in,
    input  wire logic [31:0] card_info_pointer_in,
    input  wire logic        back_to_back_capable_in,
    input  wire logic        iack_enable_in,
    input  wire logic [7:0]  int_pin_in,
    input  wire logic        hw_latency_en_in,
    input  wire logic [7:0]  hw_latency_val_in,
    input  wire logic [7:0]  min_grant_in,
    input  wire logic [7:0]  max_latency_in,
    // interrupt acknowledge command
    input  wire logic        iack_cmd,
    output logic             iack_claim,
    // interrupts
    input  wire logic        local_int_b,
    output logic             inta_b_o,
    output logic             inta_b_oe,
    // local side views
    output logic [7:0]       latency_timer_out,
    output logic [7:0]       int_line_out
);

    // ==========================================================
    // address decode helpers
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction : hit

    pchp_top_state_type st_ff;
    pchp_top_state_type nxt_st;

    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic        lat_wr;
    logic        line_wr;

    // ==========================================================
    // status dword
    pchp_status_word u_status (
        .cap_list_en_in          (cap_list_en_in),
        .back_to_back_capable_in (back_to_back_capable_in),
        .decode_speed_in         (decode_speed_in),
        .status_word             (status_word)
    );

    // ==========================================================
    // writable bytes; all other writes are dropped
    assign lat_wr = cfg_wr && hit(cfg_addr, PCHP_OFF_TIMING)
                    && cfg_be[PCHP_LANE_LATENCY];
    assign line_wr = cfg_wr && hit(cfg_addr, PCHP_OFF_INTR)
                     && cfg_be[PCHP_LANE_INTLINE];

    pchp_rw_byte u_latency (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .wr_stb       (lat_wr),
        .wr_data      (cfg_wdata[PCHP_POS_LATENCY +: 8]),
        .hardwire_en  (hw_latency_en_in),
        .hardwire_val (hw_latency_val_in),
        .value_out    (latency_timer_out)
    );

    pchp_rw_byte u_int_line (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .wr_stb       (line_wr),
        .wr_data      (cfg_wdata[PCHP_POS_INTLINE +: 8]),
        .hardwire_en  (1'b0),
        .hardwire_val (PCHP_RST_BYTE),
        .value_out    (int_line_out)
    );

    // ==========================================================
    // read data selection
    always_comb begin
        rd_word = PCHP_RST_WORD;
        if (hit(cfg_addr, PCHP_OFF_IDENT)) begin
            rd_word[15:0] = maker_ident_in;
            rd_word[31:16] = product_ident_in;
        end else if (hit(cfg_addr, PCHP_OFF_STATUS)) begin
            rd_word = status_word;
        end else if (hit(cfg_addr, PCHP_OFF_REVCLASS)) begin
            rd_word[7:0] = revision_in;
            rd_word[31:8] = class_in;
        end else if (hit(cfg_addr, PCHP_OFF_TIMING)) begin
            rd_word[PCHP_POS_LATENCY +: 8] = latency_timer_out;
        end else if (hit(cfg_addr, PCHP_OFF_CARDINFO)) begin
            rd_word = card_info_pointer_in;
        end else if (hit(cfg_addr, PCHP_OFF_SUBSYS)) begin
            rd_word[15:0] = subsystem_maker_in;
            rd_word[31:16] = subsystem_product_in;
        end else if (hit(cfg_addr, PCHP_OFF_CAPPTR)) begin
            rd_word[7:0] = cap_pointer_in;
        end else if (hit(cfg_addr, PCHP_OFF_INTR)) begin
            rd_word[PCHP_POS_INTLINE +: 8] = int_line_out;
            rd_word[PCHP_POS_INTPIN +: 8] = int_pin_in;
            rd_word[PCHP_POS_MAXLAT +: 8] = max_latency_in;
            rd_word[PCHP_POS_MINGNT +: 8] = min_grant_in;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = cfg_rd || cfg_wr;
        if (cfg_rd) begin
            nxt_st.rdata = rd_word;
        end else begin
            nxt_st.rdata = PCHP_RST_WORD;
        end
        nxt_st.iack_claim = iack_cmd && iack_enable_in;
        nxt_st.inta_oe = (int_pin_in == PCHP_INTPIN_A)
                         && !local_int_b;
    end

    // ==========================================================
    // state register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff.rdata <= PCHP_RST_WORD;
            st_ff.ack <= 1'b0;
            st_ff.inta_oe <= 1'b0;
            st_ff.iack_claim <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs
    assign cfg_ack = st_ff.ack;
    assign cfg_rdata = st_ff.rdata;
    assign iack_claim = st_ff.iack_claim;
    assign inta_b_o = 1'b0;
    assign inta_b_oe = st_ff.inta_oe;

endmodule : pchp_config_header

// *** rtl/pchp_pkg.sv ***
package pchp_pkg;

    // ==========================================================
    // configuration dword byte addresses
    localparam logic [7:0] PCHP_OFF_IDENT     = 8'h00;
    localparam logic [7:0] PCHP_OFF_STATUS    = 8'h04;
    localparam logic [7:0] PCHP_OFF_REVCLASS  = 8'h08;
    localparam logic [7:0] PCHP_OFF_TIMING    = 8'h0C;
    localparam logic [7:0] PCHP_OFF_CARDINFO  = 8'h28;
    localparam logic [7:0] PCHP_OFF_SUBSYS    = 8'h2C;
    localparam logic [7:0] PCHP_OFF_CAPPTR    = 8'h34;
    localparam logic [7:0] PCHP_OFF_INTR      = 8'h3C;

    // ==========================================================
    // field positions inside a dword
    localparam int PCHP_POS_CAPLIST   = 20;
    localparam int PCHP_POS_B2B       = 23;
    localparam int PCHP_POS_DEVSEL    = 25;
    localparam int PCHP_POS_LATENCY   = 8;
    localparam int PCHP_POS_INTLINE   = 0;
    localparam int PCHP_POS_INTPIN    = 8;
    localparam int PCHP_POS_MAXLAT    = 16;
    localparam int PCHP_POS_MINGNT    = 24;
    localparam int PCHP_LANE_LATENCY  = 1;
    localparam int PCHP_LANE_INTLINE  = 0;

    // ==========================================================
    // reset values and encodings
    localparam logic [7:0]  PCHP_RST_BYTE    = 8'h00;
    localparam logic [31:0] PCHP_RST_WORD    = 32'h0000_0000;
    localparam logic [7:0]  PCHP_INTPIN_A    = 8'h01;
    localparam logic [1:0]  PCHP_DEVSEL_SLOW = 2'h2;
    localparam logic [7:0]  PCHP_CAPPTR_DEF  = 8'h40;

    // ==========================================================
    // state types
    typedef struct packed {
        logic [7:0] val;
    } pchp_byte_state_type;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ack;
        logic        inta_oe;
        logic        iack_claim;
    } pchp_top_state_type;

endpackage : pchp_pkg

// *** rtl/pchp_rw_byte.sv ***
`timescale 1ns/1ps

module pchp_rw_byte
    import pchp_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // software write
    input  wire logic       wr_stb,
    input  wire logic [7:0] wr_data,
    // hardwire option
    input  wire logic       hardwire_en,
    input  wire logic [7:0] hardwire_val,
    // stored value
    output logic [7:0]      value_out
);

    pchp_byte_state_type st_ff;
    pchp_byte_state_type nxt_st;

    // ==========================================================
    // next value
    always_comb begin
        nxt_st = st_ff;
        if (hardwire_en) begin
            nxt_st.val = hardwire_val;
        end else if (wr_stb) begin
            nxt_st.val = wr_data;
        end
    end

    // ==========================================================
    // register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff.val <= PCHP_RST_BYTE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign value_out = st_ff.val;

endmodule : pchp_rw_byte

// *** rtl/pchp_status_word.sv ***
`timescale 1ns/1ps

module pchp_status_word
    import pchp_pkg::*;
(
    // status sources
    input  wire logic       cap_list_en_in,
    input  wire logic       back_to_back_capable_in,
    input  wire logic [1:0] decode_speed_in,
    // assembled dword
    output logic [31:0]     status_word
);

    // ==========================================================
    // status half of dword 04, command half reads zero
    always_comb begin
        status_word = PCHP_RST_WORD;
        status_word[PCHP_POS_CAPLIST] = cap_list_en_in;
        status_word[PCHP_POS_B2B] = back_to_back_capable_in;
        status_word[PCHP_POS_DEVSEL +: 2] = decode_speed_in;
    end

endmodule : pchp_status_word
